// >>> src/global_regs_map.vh
// Offsets, field positions, reset values and timing counts for the global register bank.
// Assumes a 125 MHz board clock and a 16-bit register port addressed by byte offset.
`ifndef GLOBAL_REGS_MAP_VH
`define GLOBAL_REGS_MAP_VH

`define OFS_BOARD_IDENTITY 8'h00
`define OFS_CHANNEL_RESET 8'h02
`define OFS_CHANNEL0_INFO 8'h08
`define OFS_CHANNEL1_INFO 8'h0a
`define OFS_CHANNEL2_INFO 8'h0c
`define OFS_CHANNEL3_INFO 8'h0e
`define OFS_CLOCK_SOURCE 8'h10
`define OFS_SYNC_CONTROL 8'h14
`define OFS_SECONDS_LOW 8'h16
`define OFS_DAYS_HOURS 8'h18
`define OFS_MINUTES_SECONDS 8'h1a
`define OFS_CONTROL_HIGH 8'h1c
`define OFS_CONTROL_LOW 8'h1e
`define OFS_LOGIC_REVISION 8'h20
`define OFS_TIMER_PRESCALE 8'h22
`define OFS_TIMER_PRELOAD 8'h24
`define OFS_TIMER_CONTROL 8'h26
`define OFS_TIMER_COUNT 8'h28
`define OFS_BOARD_KIND 8'h32

`define BIT_TIMETAG_RESET 4
`define BIT_SYNC_ARM 8
`define BIT_SYNC_STORE 9
`define BIT_SYNC_DONE 10
`define POS_CHANNEL_ID 12
`define BIT_TIMER_RUN 0
`define BIT_TIMER_RELOAD 1
`define BIT_TIMER_GLOBAL_RESET 3

`define RST_CLOCK_SOURCE 1'b0
`define RST_TIMER_PRESCALE 16'h0000
`define RST_TIMER_PRELOAD 16'h0000
`define RST_TIMER_CONTROL 4'h0

// Time code element widths in microseconds, and the board clock rate in MHz.
`define CLK_MHZ 125
`define CODE_ZERO_US 2000
`define CODE_ONE_US 5000
`define CODE_MARK_US 8000
// A zero lasts 2 ms, a one 5 ms and a marker 8 ms; split the gaps between them.
`define CODE_ONE_MIN_CYC ((`CODE_ZERO_US + `CODE_ONE_US) / 2 * `CLK_MHZ)
`define CODE_MARK_MIN_CYC ((`CODE_ONE_US + `CODE_MARK_US) / 2 * `CLK_MHZ)

`endif

// >>> src/host_global_regs.v
// Global register bank: identity, channel resets, time tag clock source,
// serial time code receiver and the general purpose down timer.
// Assumes the time code arrives already demodulated as a pulse-width level on
// timeCodeIn, and the external time tag clock as a plain level on extTagClk.
`timescale 1ns/1ns
`include "global_regs_map.vh"

module host_global_regs #(
    parameter [15:0] BOARD_IDENTITY = 16'h1234, // Arbitrary value.
    parameter [15:0] BOARD_KIND = 16'h00a5, // Arbitrary value.
    parameter [15:0] LOGIC_REV = 16'h0001, // Arbitrary value.
    parameter [4:0] CH0_TYPE = 5'h01, // Arbitrary type code.
    parameter [4:0] CH1_TYPE = 5'h01, // Arbitrary type code.
    parameter [4:0] CH2_TYPE = 5'h1e, // Arbitrary type code.
    parameter [4:0] CH3_TYPE = 5'h02, // Arbitrary type code.
    parameter integer TICK_DIV = 125, // Board cycles per internal 1 MHz tick.
    parameter integer ONE_MIN = `CODE_ONE_MIN_CYC, // Shortest high time read as a one.
    parameter integer MARK_MIN = `CODE_MARK_MIN_CYC // Shortest high time read as a marker.
) (
    input wire clk, // Board clock, 125 MHz.
    input wire rst, // Synchronous reset, active high.
    input wire [7:0] addr, // Register byte offset.
    input wire [15:0] wrData, // Write data.
    input wire wrEn, // Write strobe.
    input wire rdEn, // Read strobe.
    output reg [15:0] rdData, // Read data, valid the cycle after rdEn.
    input wire timeCodeIn, // Demodulated time code level.
    input wire extTagClk, // External time tag clock.
    output reg [2:0] channelReset, // One-cycle reset for each of channels 0 to 2; channel 3 has none.
    output reg tagClear, // One-cycle clear of every time tag.
    output wire tagClkSelect, // High when the external tag clock is used.
    output reg timerDone // One-cycle pulse when the timer reaches zero.
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three stages, a change counts once stages two and
    // three agree.
    reg [2:0] codeSync_q; // Time code synchroniser.
    reg [2:0] extSync_q; // External clock synchroniser.
    reg codeLvl_q; // Filtered time code level.
    reg extLvl_q; // Filtered external clock level.

    // The first stage feeds only the second; the filter reads stages two and three.
    always @(posedge clk) begin
        if (rst) begin
            codeSync_q <= 3'h0;
            extSync_q <= 3'h0;
            codeLvl_q <= 1'b0;
            extLvl_q <= 1'b0;
        end else begin
            codeSync_q <= {codeSync_q[1:0], timeCodeIn};
            extSync_q <= {extSync_q[1:0], extTagClk};
            if (codeSync_q[1] == codeSync_q[2]) begin
                codeLvl_q <= codeSync_q[2];
            end
            if (extSync_q[1] == extSync_q[2]) begin
                extLvl_q <= extSync_q[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers.
    reg clkSel_q; // Time tag clock source.
    reg [2:0] sync_q; // Bits 10..8 of the sync register.
    reg [15:0] prescale_q; // Timer prescale.
    reg [15:0] preload_q; // Timer preload.
    reg [3:0] tctl_q; // Timer control.
    reg [15:0] count_q; // Timer current count.
    reg [16:0] sodOut_q; // Stored seconds-of-day.
    reg [15:0] dayHour_q; // Stored days and hours.
    reg [15:0] minSec_q; // Stored minutes and seconds.
    reg [26:0] ctrlOut_q; // Stored control functions.

    wire wrSync = wrEn && (addr == `OFS_SYNC_CONTROL);
    wire wrCtl = wrEn && (addr == `OFS_TIMER_CONTROL);
    wire running = tctl_q[`BIT_TIMER_RUN];

    assign tagClkSelect = clkSel_q;

    ////////////////////////////////////////////////////////////////////////////
    // Time tag tick: internal 1 MHz divider or external rising edge.
    reg [7:0] divCnt_q; // Internal microsecond divider.
    reg extPrev_q; // Previous filtered external level.
    wire intTick = (divCnt_q == TICK_DIV[7:0] - 8'h01);
    wire tagTick = clkSel_q ? (extLvl_q && !extPrev_q) : intTick;

    // Free-running divider and edge history.
    always @(posedge clk) begin
        if (rst) begin
            divCnt_q <= 8'h00;
            extPrev_q <= 1'b0;
        end else begin
            divCnt_q <= intTick ? 8'h00 : divCnt_q + 8'h01;
            extPrev_q <= extLvl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time code receiver. Each element is measured by its high time; two
    // markers in a row mark the frame start, whose leading edge is the
    // on-time reference edge.
    localparam [1:0] SYM_ZERO = 2'd0;
    localparam [1:0] SYM_ONE = 2'd1;
    localparam [1:0] SYM_MARK = 2'd2;

    reg codePrev_q; // Previous filtered code level.
    reg [19:0] hiCnt_q; // Length of the current high time.
    reg [6:0] elem_q; // Element index within the frame.
    reg inFrame_q; // A frame start has been seen.
    reg lastMark_q; // Previous element was a marker.
    reg [99:0] shift_q; // Frame elements, element n at bit n.
    reg frameValid_q; // A complete frame is held.
    reg [99:0] frame_q; // Last complete frame.

    wire codeRise = codeLvl_q && !codePrev_q;
    wire codeFall = !codeLvl_q && codePrev_q;
    wire [1:0] sym = (hiCnt_q >= MARK_MIN) ? SYM_MARK :
                     (hiCnt_q >= ONE_MIN) ? SYM_ONE : SYM_ZERO;
    // The rising edge starting element zero is the reference edge.
    wire refEdge = codeRise && lastMark_q && (elem_q == 7'd0 || elem_q == 7'd100);

    // Element classifier and frame assembler.
    always @(posedge clk) begin
        if (rst) begin
            codePrev_q <= 1'b0;
            hiCnt_q <= 20'h00000;
            elem_q <= 7'd0;
            inFrame_q <= 1'b0;
            lastMark_q <= 1'b0;
            shift_q <= 100'h0;
            frameValid_q <= 1'b0;
            frame_q <= 100'h0;
        end else begin
            codePrev_q <= codeLvl_q;
            if (codeRise) begin
                hiCnt_q <= 20'h00001;
            end else if (codeLvl_q && hiCnt_q != 20'hfffff) begin
                hiCnt_q <= hiCnt_q + 20'h00001;
            end
            if (codeFall) begin
                lastMark_q <= (sym == SYM_MARK);
                if (sym == SYM_MARK && lastMark_q) begin
                    // Second marker in a row: this was element zero.
                    if (inFrame_q && elem_q == 7'd100) begin
                        frame_q <= shift_q;
                        frameValid_q <= 1'b1;
                    end
                    inFrame_q <= 1'b1;
                    shift_q <= 100'h0;
                    elem_q <= 7'd1;
                end else if (inFrame_q && elem_q < 7'd100) begin
                    shift_q[elem_q] <= (sym == SYM_ONE);
                    elem_q <= elem_q + 7'd1;
                end else begin
                    inFrame_q <= 1'b0;
                end
            end
        end
    end

    // BCD and binary fields picked out of a frame, skipping marker slots.
    wire [6:0] fSec = {frame_q[8:6], frame_q[4:1]};
    wire [6:0] fMin = {frame_q[17:15], frame_q[13:10]};
    wire [5:0] fHour = {frame_q[26:25], frame_q[23:20]};
    // Day hundreds sit just after the marker that follows the day tens.
    wire [9:0] fDay = {frame_q[41:40], frame_q[38:35], frame_q[33:30]};
    wire [26:0] fCtrl = {frame_q[78:70], frame_q[68:60], frame_q[58:50]};
    wire [16:0] fSod = {frame_q[97:90], frame_q[88:80]};

    ////////////////////////////////////////////////////////////////////////////
    // Sync control and time registers. An armed sync waits for the reference
    // edge; a plain store request latches the last good frame at once.
    wire storeNow = sync_q[1] && frameValid_q && (!sync_q[0] || refEdge);

    // Sync bits, resets, clock source and stored time.
    always @(posedge clk) begin
        if (rst) begin
            clkSel_q <= `RST_CLOCK_SOURCE;
            sync_q <= 3'h0;
            sodOut_q <= 17'h0;
            dayHour_q <= 16'h0;
            minSec_q <= 16'h0;
            ctrlOut_q <= 27'h0;
            channelReset <= 3'h0;
            tagClear <= 1'b0;
        end else begin
            channelReset <= 3'h0;
            tagClear <= 1'b0;
            if (wrEn && addr == `OFS_CHANNEL_RESET) begin
                channelReset <= wrData[2:0];
                tagClear <= wrData[`BIT_TIMETAG_RESET];
            end
            if (wrEn && addr == `OFS_CLOCK_SOURCE) begin
                clkSel_q <= wrData[0];
            end
            if (sync_q[0] && refEdge) begin
                tagClear <= 1'b1;
            end
            if (tctl_q[`BIT_TIMER_GLOBAL_RESET] && timerDone) begin
                channelReset <= 3'h7;
            end
            if (storeNow) begin
                sodOut_q <= fSod;
                dayHour_q <= {fDay, fHour};
                minSec_q <= {1'b0, fMin, 1'b0, fSec};
                ctrlOut_q <= fCtrl;
            end
            // Bit 10 set by hardware wins over a software clear in the same cycle.
            sync_q[2] <= storeNow | (wrSync ? wrData[`BIT_SYNC_DONE] : sync_q[2]);
            // Arming also requests the store.
            sync_q[1] <= storeNow ? 1'b0 : (wrSync ? (wrData[`BIT_SYNC_STORE] |
                         wrData[`BIT_SYNC_ARM]) : sync_q[1]);
            sync_q[0] <= (sync_q[0] && refEdge) ? 1'b0 :
                         (wrSync ? wrData[`BIT_SYNC_ARM] : sync_q[0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General purpose timer.
    reg [15:0] preCnt_q; // Tag ticks since the last decrement.
    wire [15:0] divisor = (prescale_q == 16'h0000) ? 16'h0001 : prescale_q;
    wire step = running && tagTick && (preCnt_q + 16'h0001 >= divisor);
    wire startReq = wrCtl && wrData[`BIT_TIMER_RUN] && !running;
    // A start from zero count takes the preload; zero preload refuses it.
    wire startOk = (count_q != 16'h0000) || (preload_q != 16'h0000);

    // Prescale, preload, control and count.
    always @(posedge clk) begin
        if (rst) begin
            prescale_q <= `RST_TIMER_PRESCALE;
            preload_q <= `RST_TIMER_PRELOAD;
            tctl_q <= `RST_TIMER_CONTROL;
            count_q <= 16'h0000;
            preCnt_q <= 16'h0000;
            timerDone <= 1'b0;
        end else begin
            timerDone <= 1'b0;
            if (wrEn && addr == `OFS_TIMER_PRESCALE && !running) begin
                prescale_q <= wrData;
            end
            if (wrEn && addr == `OFS_TIMER_PRELOAD && !running) begin
                preload_q <= wrData;
                count_q <= wrData;
            end
            if (wrCtl) begin
                if (!running) begin
                    tctl_q[3:1] <= {wrData[3], 1'b0, wrData[1]};
                end
                if (!wrData[`BIT_TIMER_RUN]) begin
                    tctl_q[0] <= 1'b0;
                end else if (startReq && startOk) begin
                    tctl_q[0] <= 1'b1;
                    preCnt_q <= 16'h0000;
                    if (count_q == 16'h0000) begin
                        count_q <= preload_q;
                    end
                end
            end else if (running && tagTick) begin
                preCnt_q <= step ? 16'h0000 : preCnt_q + 16'h0001;
                if (step) begin
                    if (count_q <= 16'h0001) begin
                        timerDone <= 1'b1;
                        if (tctl_q[`BIT_TIMER_RELOAD]) begin
                            count_q <= preload_q;
                        end else begin
                            count_q <= 16'h0000;
                            tctl_q[0] <= 1'b0;
                        end
                    end else begin
                        count_q <= count_q - 16'h0001;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped offsets and reserved bits read zero.
    // Read-only offsets have no write decode at all.
    always @(posedge clk) begin
        if (rst) begin
            rdData <= 16'h0000;
        end else if (rdEn) begin
            case (addr)
                `OFS_BOARD_IDENTITY: rdData <= BOARD_IDENTITY;
                `OFS_CHANNEL0_INFO: rdData <= {4'h0, 7'h00, CH0_TYPE};
                `OFS_CHANNEL1_INFO: rdData <= {4'h1, 7'h00, CH1_TYPE};
                `OFS_CHANNEL2_INFO: rdData <= {4'h2, 7'h00, CH2_TYPE};
                `OFS_CHANNEL3_INFO: rdData <= {4'h3, 7'h00, CH3_TYPE};
                `OFS_CLOCK_SOURCE: rdData <= {15'h0000, clkSel_q};
                `OFS_SYNC_CONTROL: rdData <= {5'h00, sync_q, 7'h00, sodOut_q[16]};
                `OFS_SECONDS_LOW: rdData <= sodOut_q[15:0];
                `OFS_DAYS_HOURS: rdData <= dayHour_q;
                `OFS_MINUTES_SECONDS: rdData <= minSec_q;
                `OFS_CONTROL_HIGH: rdData <= {5'h00, ctrlOut_q[26:16]};
                `OFS_CONTROL_LOW: rdData <= ctrlOut_q[15:0];
                `OFS_LOGIC_REVISION: rdData <= LOGIC_REV;
                `OFS_TIMER_PRESCALE: rdData <= prescale_q;
                `OFS_TIMER_PRELOAD: rdData <= preload_q;
                `OFS_TIMER_CONTROL: rdData <= {12'h000, tctl_q};
                `OFS_TIMER_COUNT: rdData <= count_q;
                `OFS_BOARD_KIND: rdData <= BOARD_KIND;
                default: rdData <= 16'h0000;
            endcase
        end else begin
            rdData <= 16'h0000;
        end
    end

endmodule // host_global_regs

// >>> verification/global_regs_props.sv
// Port-level checks on the global register bank.
// Assumes one board clock and the synchronous active-high reset.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
module global_regs_props #(
    parameter [15:0] BOARD_IDENTITY = 16'h1234, // Arbitrary value.
    parameter [4:0] CH0_TYPE = 5'h01 // Arbitrary type code.
) (
    input wire clk, // Board clock.
    input wire rst, // Synchronous reset.
    input wire [7:0] addr, // Register offset.
    input wire [15:0] wrData, // Write data.
    input wire wrEn, // Write strobe.
    input wire rdEn, // Read strobe.
    input wire [15:0] rdData, // Read data.
    input wire [2:0] channelReset, // Channel reset pulses.
    input wire tagClear, // Time tag clear pulse.
    input wire tagClkSelect, // Tag clock source.
    input wire timerDone // Timer zero pulse.
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    // A write then a read of one place; the bus leaves one idle cycle between.
    sequence selWriteRead;
        wrEn && addr == 8'h10 ##2 rdEn && addr == 8'h10;
    endsequence
    sequence idWriteRead;
        wrEn && addr == 8'h00 ##2 rdEn && addr == 8'h00;
    endsequence
    chk_read_idle: assert property (!$past(rdEn) |-> rdData == 16'h0000)
        else $error("read data not zero outside a read");
    chk_board_identity: assert property (rdEn && addr == 8'h00 |=> rdData == BOARD_IDENTITY)
        else $error("identity read wrong");
    chk_id_write: assert property (idWriteRead |=> rdData == BOARD_IDENTITY)
        else $error("identity changed by a write");
    chk_chan_info: assert property (rdEn && addr == 8'h08 |=> rdData == {11'h000, CH0_TYPE})
        else $error("channel info wrong");
    chk_chan_reset: assert property (wrEn && addr == 8'h02 |=> channelReset == $past(wrData[2:0]))
        else $error("channel reset pulse wrong");
    chk_tag_clear: assert property (wrEn && addr == 8'h02 && wrData[4] |=> tagClear)
        else $error("tag clear missing");
    chk_sel_readback: assert property (selWriteRead |=>
        rdData == {15'h0000, $past(wrData[0], 3)} && tagClkSelect == $past(wrData[0], 3))
        else $error("clock select wrong");
    chk_sel_hold: assert property (!(wrEn && addr == 8'h10) |=> $stable(tagClkSelect))
        else $error("clock select moved");
    chk_sbs_gaps: assert property (rdEn && addr == 8'h14 |=>
        rdData[15:11] == 5'h00 && rdData[7:1] == 7'h00)
        else $error("sync register reserved bits set");
    chk_minsec_gaps: assert property (rdEn && addr == 8'h1a |=> !rdData[15] && !rdData[7])
        else $error("minutes register reserved bits set");
    chk_cf_high: assert property (rdEn && addr == 8'h1c |=> rdData[15:11] == 5'h00)
        else $error("control high reserved bits set");
    // One internal tick is 125 board cycles, so two ends on the internal clock are never close.
    chk_done_gap: assert property (timerDone |=> !timerDone [*8])
        else $error("timer ends too close");
endmodule // global_regs_props

bind host_global_regs global_regs_props #(.BOARD_IDENTITY(BOARD_IDENTITY), .CH0_TYPE(CH0_TYPE))
    global_regs_props_inst (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .channelReset(channelReset),
    .tagClear(tagClear), .tagClkSelect(tagClkSelect), .timerDone(timerDone));

// >>> verification/tb.sv
// Self-checking bench for the global register bank.
// Assumes short time code elements: zero 15, one 45, marker 75 of 100 cycles, split at 30 and 60.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
module tb;
    localparam [15:0] BOARD_IDENTITY = 16'h1234; // Arbitrary value.
    localparam [15:0] BOARD_KIND = 16'h00a5; // Arbitrary value.
    localparam [15:0] LOGIC_REV = 16'h0001; // Arbitrary value.
    localparam [19:0] CH_TYPES = {5'h02, 5'h1e, 5'h01, 5'h01}; // Arbitrary codes.
    logic clk = 1'b0, rst = 1'b1, wrEn = 1'b0, rdEn = 1'b0;
    logic timeCodeIn = 1'b0, extTagClk = 1'b0, rdSeen = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wrData = 16'h0000;
    wire [15:0] rdData;
    wire [2:0] channelReset;
    wire tagClear, tagClkSelect, timerDone;
    logic [15:0] readQ[$]; // Expected read data, oldest first.
    logic [4:0] eventQ[$]; // Expected {timerDone, tagClear, channelReset}.
    logic [99:0] frm; // One time code frame, one bit per element.
    logic [26:0] cf; // Random control functions.
    int n_errors = 0, n_checks = 0, cyc = 0, lastDone = 0, doneGap = 0, rnd, pre, t0;

    // Identity and type codes use the design defaults, mirrored by the localparams above.
    host_global_regs #(.ONE_MIN(30), .MARK_MIN(60)) host_global_regs_inst (
        .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
        .rdData(rdData), .timeCodeIn(timeCodeIn), .extTagClk(extTagClk),
        .channelReset(channelReset), .tagClear(tagClear), .tagClkSelect(tagClkSelect),
        .timerDone(timerDone));

    initial begin
        forever #4 clk = ~clk;
    end
    // External tag clock: a rising edge every 10 cycles, free running.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 5 == 4) extTagClk <= ~extTagClk;
    end
    ////////////////////////////////////////////////////////////////
    task checkWord(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task checkEvent(input logic [4:0] got, input logic [4:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Reads answer one cycle late; pulses are matched against the oldest note.
    always @(posedge clk) begin
        if (rdSeen) checkWord(rdData, readQ.pop_front());
        rdSeen <= rdEn;
        if ({timerDone, tagClear, channelReset} !== 5'h00) begin
            if (timerDone === 1'b1) begin
                doneGap = cyc - lastDone;
                lastDone = cyc;
            end
            checkEvent({timerDone, tagClear, channelReset}, eventQ.size() ? eventQ.pop_front() : 5'h00);
        end
    end
    ////////////////////////////////////////////////////////////////
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        readQ.push_back(e);
        @(posedge clk);
        rdEn <= 1'b0;
    endtask
    // Waits, bounded, until every noted result has been seen.
    task drain(input int lim);
        int i;
        for (i = 0; i < lim && eventQ.size() + readQ.size() != 0; i++) @(posedge clk);
        if (i == lim) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, eventQ.size(), 0);
        end
    endtask
    task elem(input int kind);
        int hi;
        hi = kind == 2 ? 75 : (kind == 1 ? 45 : 15);
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            timeCodeIn <= (i < hi);
        end
    endtask
    // Elements 1 to 99; every tenth is a position marker.
    task body;
        for (int p = 1; p < 100; p++) elem(p % 10 == 9 ? 2 : int'(frm[p]));
    endtask
    task put(input int pos, input int w, input int v);
        for (int i = 0; i < w; i++) frm[pos + i] = v[i];
    endtask
    task readTime(input logic [15:0] sync);
        rd(8'h14, sync);
        rd(8'h16, 16'hbcd1);
        rd(8'h18, 16'h48d3);
        rd(8'h1a, 16'h2537);
        rd(8'h1c, {5'h00, cf[26:16]});
        rd(8'h1e, cf[15:0]);
    endtask
    task summarize;
        if (n_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        summarize;
    end
    initial begin
        rnd = $urandom(32'hee7cd60f);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, BOARD_IDENTITY);
        wr(8'h00, ~BOARD_IDENTITY);
        rd(8'h00, BOARD_IDENTITY);
        for (int c = 0; c < 4; c++) rd(8'(8 + 2 * c), {c[3:0], 7'h00, CH_TYPES[5 * c +: 5]});
        wr(8'h20, 16'hffff);
        rd(8'h20, LOGIC_REV);
        rd(8'h32, BOARD_KIND);
        rd(8'h06, 16'h0000);
        eventQ.push_back(5'h0f);
        wr(8'h02, 16'h0017);
        wr(8'h02, 16'hffe8);
        for (int k = 0; k < 8; k++) begin
            rnd = $urandom;
            if ({rnd[4], rnd[2:0]} != 4'h0) eventQ.push_back({1'b0, rnd[4], rnd[2:0]});
            wr(8'h02, {11'h000, rnd[4:0]});
        end
        rd(8'h10, 16'h0000);
        wr(8'h10, 16'hffff);
        rd(8'h10, 16'h0001);
        wr(8'h10, 16'h0000);
        rd(8'h24, 16'h0000);
        wr(8'h26, 16'h0001);
        rd(8'h26, 16'h0000);
        // One-shot on the internal tick; prescale zero means one tick.
        pre = 2 + $urandom % 4;
        wr(8'h22, 16'h0000);
        wr(8'h24, pre[15:0]);
        eventQ.push_back(5'h10);
        wr(8'h26, 16'h0001);
        t0 = cyc;
        drain(pre * 125 + 200);
        checkWord({15'h0000, lastDone - t0 > (pre - 1) * 125 && lastDone - t0 < pre * 125 + 9}, 16'h0001);
        rd(8'h28, 16'h0000);
        rd(8'h26, 16'h0000);
        // Reload on the external clock: 2 x 3 ticks of 10 cycles apart.
        wr(8'h10, 16'h0001);
        wr(8'h22, 16'h0002);
        wr(8'h24, 16'h0003);
        repeat (3) eventQ.push_back(5'h10);
        wr(8'h26, 16'h0003);
        wr(8'h22, 16'h0005);
        wr(8'h24, 16'h0007);
        drain(400);
        checkWord(doneGap[15:0], 16'd60);
        wr(8'h26, 16'h0000);
        rd(8'h22, 16'h0002);
        rd(8'h24, 16'h0003);
        rd(8'h26, 16'h0002);
        wr(8'h10, 16'h0000);
        // Time code 123 days 13:25:37, seconds of day 48337.
        cf = 27'($urandom);
        frm = '0;
        put(1, 4, 7); put(6, 3, 3); put(10, 4, 5); put(15, 3, 2); put(20, 4, 3);
        put(25, 2, 1); put(30, 4, 3); put(35, 4, 2); put(40, 2, 1); put(50, 9, cf);
        put(60, 9, cf >> 9); put(70, 9, cf >> 18); put(80, 9, 48337); put(90, 8, 48337 >> 9);
        elem(2);
        elem(2);
        body;
        elem(2);
        body;
        elem(2);
        wr(8'h14, 16'h0200);
        readTime(16'h0400);
        wr(8'h14, 16'h0000);
        rd(8'h14, 16'h0000);
        eventQ.push_back(5'h08);
        wr(8'h14, 16'h0100);
        body;
        elem(2);
        drain(300);
        readTime(16'h0400);
        drain(10);
        summarize;
    end
endmodule // tb
